// [hdl/sds_sequencer.sv]
// Sixteen-step drum sequencer evaluated once per controller scan.
// Notes on behaviour
// RL1 - Sixteen steps, each with its own sixteen-bit output pattern.
// RL2 - Timed variant advances only on elapsed counts against the step's count.
// RL3 - The program sets unused timed steps to a count of zero.
// RL4 - Timer runs while start is on; sequencing stops at last step or reset.
// RL5 - Preset step loads on entry to run mode and while reset is on.
// RL6 - Event variants count time only while the step's event is true.
// RL7 - Step advances when the count in step equals the programmed count.
// RL8 - Event variants advance one step on each rising jog edge.
// RL9 - Four status words: count in step, timer, preset step, current step.
// RL10 - Preset word is writable any time; other words are read only.
// RL11 - Completion bit sets when the last step ends and clears on reset.
// RL12 - Zero counts with true events complete one step per scan.
// RL13 - Outputs follow the current step pattern every scan in run mode.
// RL14 - Masked variant ANDs each pattern bit with the step's mask word bit.
// RL15 - Sixteen mask words are read consecutively from a chosen start.
// RL16 - Blank steps and events mean no count and no event condition.
// RL17 - One timer count lasts the timebase value times 0.01 seconds.
// RL18 - Reset beats start; under reset neither time nor events act.
// RL19 - With start off, reset off and no jog edge, state and outputs freeze.
// RL20 - Jog acts only with reset off, whatever the start input.
// RL21 - After the last step, hold outputs and ignore start and jog until reset.
// RL22 - Inputs, timer and transitions are evaluated once per scan tick.
// RL23 - Every step change clears the count in step.
module sds_sequencer #(
	parameter int HUNDREDTH_CYCLES = sds_pkg::HUNDREDTH_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Controller scan and mode
	input wire logic scan_tick,
	input wire logic run_mode,
	input wire sds_pkg::sds_variant_t variant,
	// Control contacts
	input wire logic start,
	input wire logic jog,
	input wire logic reset_in,
	// Step programme
	input wire logic [sds_pkg::STEP_W-1:0] last_step,
	input wire logic [sds_pkg::HUND_W-1:0] timebase_value,
	input wire logic [sds_pkg::STEPS*sds_pkg::CNT_W-1:0] counts_flat,
	input wire logic [sds_pkg::STEPS*sds_pkg::OUTS-1:0] pattern_flat,
	input wire logic [sds_pkg::STEPS-1:0] event_used,
	input wire logic [sds_pkg::STEPS-1:0] event_in,
	// Mask words
	input wire logic [sds_pkg::STEPS*sds_pkg::WORD_W-1:0] mask_flat,
	input wire logic [sds_pkg::IDX_W-1:0] mask_base,
	// Preset step write
	input wire logic preset_wr,
	input wire logic [sds_pkg::STEP_W-1:0] preset_step_value,
	// Drum outputs and status
	output logic [sds_pkg::OUTS-1:0] drum_out,
	output logic drum_done,
	output logic [sds_pkg::WORD_W-1:0] status_count,
	output logic [sds_pkg::WORD_W-1:0] status_timer,
	output logic [sds_pkg::WORD_W-1:0] status_preset,
	output logic [sds_pkg::WORD_W-1:0] status_step
);
	logic [sds_pkg::CNT_W-1:0] step_counts [sds_pkg::STEPS];
	logic [sds_pkg::OUTS-1:0] step_pattern [sds_pkg::STEPS];
	logic [sds_pkg::WORD_W-1:0] mask_word [sds_pkg::STEPS];

	sds_pkg::sds_state_t state_q;
	sds_pkg::sds_state_t state_d;
	logic [sds_pkg::STEP_W-1:0] step_q;
	logic [sds_pkg::STEP_W-1:0] step_d;
	logic [sds_pkg::STEP_W-1:0] preset_q;
	logic [sds_pkg::CNT_W-1:0] count_q;
	logic [sds_pkg::CNT_W-1:0] count_d;
	logic done_q;
	logic done_d;
	logic jog_prev_q;
	logic run_prev_q;
	logic tick_pend_q;
	logic [sds_pkg::OUTS-1:0] out_q;

	logic [sds_pkg::IDX_W-1:0] cur_idx;
	logic [sds_pkg::IDX_W-1:0] mask_idx;
	logic event_variant;
	logic cur_event_ok;
	logic load_preset;
	logic jog_rise;
	logic timer_run;
	logic count_pulse;
	logic step_clear;
	logic [sds_pkg::HUND_W-1:0] hundredths;
	logic [sds_pkg::OUTS-1:0] out_next;

	// Step number 1..16 to array index 0..15.
	function automatic logic [sds_pkg::IDX_W-1:0] step_index(input logic [sds_pkg::STEP_W-1:0] num);
		logic [sds_pkg::STEP_W-1:0] tmp;
		tmp = num - sds_pkg::STEP_FIRST;
		return tmp[sds_pkg::IDX_W-1:0];
	endfunction : step_index

	genvar gi;
	generate
		for (gi = 0; gi < sds_pkg::STEPS; gi++) begin : g_unpack
			assign step_counts[gi] = counts_flat[gi*sds_pkg::CNT_W +: sds_pkg::CNT_W]; // [RL1]
			assign step_pattern[gi] = pattern_flat[gi*sds_pkg::OUTS +: sds_pkg::OUTS]; // [RL1]
			assign mask_word[gi] = mask_flat[gi*sds_pkg::WORD_W +: sds_pkg::WORD_W];
		end
	endgenerate

	assign cur_idx = step_index(step_q);
	// Mask words are taken consecutively from the base, wrapping within sixteen.
	assign mask_idx = mask_base + cur_idx; // [RL15]
	assign event_variant = (variant != sds_pkg::SDS_TIMED);
	// A blank event imposes no condition, so the step runs on time alone.
	assign cur_event_ok = !event_variant || !event_used[cur_idx] || event_in[cur_idx]; // [RL6] [RL16]
	assign load_preset = scan_tick && run_mode && (reset_in || !run_prev_q); // [RL5] [RL18]
	assign jog_rise = jog && !jog_prev_q;
	assign timer_run = run_mode && start && !reset_in && (state_q == sds_pkg::SDS_RUN) && cur_event_ok; // [RL4] [RL6]

	sds_timebase #(
		.HUNDREDTH_CYCLES(HUNDREDTH_CYCLES)
	) u_timebase (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.run(timer_run),
		.clear(step_clear),
		.timebase_value(timebase_value),
		.count_pulse(count_pulse), // [RL17]
		.hundredths(hundredths)
	);

	always_comb begin
		state_d = state_q;
		step_d = step_q;
		count_d = count_q;
		done_d = done_q;
		if (!run_mode) begin
			state_d = sds_pkg::SDS_PROG;
		end else if (state_q == sds_pkg::SDS_PROG || reset_in) begin
			state_d = sds_pkg::SDS_RUN; // [RL5] [RL18]
			step_d = preset_q;
			count_d = sds_pkg::COUNT_BLANK;
			done_d = 1'b0; // [RL11]
		end else if (state_q == sds_pkg::SDS_RUN) begin
			if (event_variant && jog_rise) begin
				count_d = sds_pkg::COUNT_BLANK; // [RL8] [RL20] [RL23]
				if (step_q >= last_step) begin
					state_d = sds_pkg::SDS_DONE;
					done_d = 1'b1;
				end else begin
					step_d = step_q + sds_pkg::STEP_FIRST;
				end
			end else if (start && cur_event_ok) begin
				if (count_q == step_counts[cur_idx]) begin
					count_d = sds_pkg::COUNT_BLANK; // [RL7] [RL12] [RL23]
					if (step_q >= last_step) begin
						state_d = sds_pkg::SDS_DONE; // [RL11] [RL21]
						done_d = 1'b1;
					end else begin
						step_d = step_q + sds_pkg::STEP_FIRST;
					end
				end else if (tick_pend_q) begin
					count_d = count_q + 14'h0001; // [RL2]
				end
			end
		end
	end

	// Step change clears the timebase so a new step starts a fresh count.
	assign step_clear = scan_tick && ((step_d != step_q) || (count_d == sds_pkg::COUNT_BLANK && count_q != count_d));

	// Scan-rate state update; between scans everything stands.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= sds_pkg::SDS_PROG;
			step_q <= sds_pkg::PRESET_RESET;
			count_q <= sds_pkg::COUNT_BLANK;
			done_q <= 1'b0;
		end else if (scan_tick) begin
			state_q <= state_d; // [RL22] [RL19]
			step_q <= step_d;
			count_q <= count_d;
			done_q <= done_d;
		end
	end

	// Timer counts that arrive between scans wait for the next scan.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tick_pend_q <= 1'b0;
		end else if (scan_tick) begin
			// A count that lands on the scan edge itself is kept for the next scan.
			tick_pend_q <= count_pulse; // [RL22]
		end else if (count_pulse) begin
			tick_pend_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			jog_prev_q <= 1'b0;
			run_prev_q <= 1'b0;
		end else if (scan_tick) begin
			jog_prev_q <= jog;
			run_prev_q <= run_mode;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			preset_q <= sds_pkg::PRESET_RESET;
		end else if (preset_wr) begin
			preset_q <= preset_step_value; // [RL10]
		end
	end

	// Outputs reflect the step that the scan has just settled on.
	always_comb begin
		out_next = step_pattern[step_index(step_d)];
		if (variant == sds_pkg::SDS_MASKED) begin
			out_next = out_next & mask_word[step_index(step_d) + mask_base]; // [RL14]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			out_q <= '0;
		end else if (scan_tick) begin
			out_q <= run_mode ? out_next : '0; // [RL13]
		end
	end

	assign drum_out = out_q;
	assign drum_done = done_q;
	assign status_count = {2'h0, count_q}; // [RL9]
	assign status_timer = {2'h0, hundredths};
	assign status_preset = {11'h000, preset_q};
	assign status_step = {11'h000, step_q};

	property p_preset_load;
		@(posedge clk_sys) disable iff (sys_rst)
		load_preset |=> (step_q == $past(preset_q)) && !done_q && count_q == sds_pkg::COUNT_BLANK;
	endproperty
	a_preset_load: assert property (p_preset_load) else $error("preset not loaded"); // [RL5]

	property p_reset_holds;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && reset_in ##1 reset_in [*2] |-> !timer_run && !done_q;
	endproperty
	a_reset_holds: assert property (p_reset_holds) else $error("reset did not hold drum"); // [RL18]

	property p_freeze;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && state_q == sds_pkg::SDS_RUN && !start && !reset_in && !jog_rise
		|=> $stable(step_q) && $stable(count_q) && $stable(drum_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("drum moved with start off"); // [RL19]

	property p_jog;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && state_q == sds_pkg::SDS_RUN && !reset_in && event_variant && jog_rise
		&& step_q < last_step |=> step_q == $past(step_q) + sds_pkg::STEP_FIRST && count_q == '0;
	endproperty
	a_jog: assert property (p_jog) else $error("jog did not advance one step"); // [RL8]

	property p_zero_count;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && state_q == sds_pkg::SDS_RUN && start && !reset_in && !jog_rise
		&& cur_event_ok && step_counts[cur_idx] == count_q && step_q < last_step
		|=> step_q == $past(step_q) + sds_pkg::STEP_FIRST;
	endproperty
	a_zero_count: assert property (p_zero_count) else $error("step not advanced on equal count"); // [RL12]

	property p_done_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		state_q == sds_pkg::SDS_DONE && run_mode && !reset_in |=> $stable(step_q) && $stable(drum_out) && done_q;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("complete state not held"); // [RL21]

	property p_step_clears_count;
		@(posedge clk_sys) disable iff (sys_rst)
		$changed(step_q) |-> count_q == sds_pkg::COUNT_BLANK;
	endproperty
	a_step_clears_count: assert property (p_step_clears_count) else $error("count kept over step"); // [RL23]

	property p_mask;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && variant == sds_pkg::SDS_MASKED ##1 $stable(step_q) && $stable(mask_flat)
		&& $stable(mask_base) && $stable(pattern_flat)
		|-> drum_out == (step_pattern[cur_idx] & mask_word[mask_idx]);
	endproperty
	a_mask: assert property (p_mask) else $error("masked output wrong"); // [RL14]

	property p_outputs;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && variant != sds_pkg::SDS_MASKED |=> drum_out == step_pattern[cur_idx];
	endproperty
	a_outputs: assert property (p_outputs) else $error("output not current pattern"); // [RL13]

	property p_event_gate;
		@(posedge clk_sys) disable iff (sys_rst)
		event_variant && event_used[cur_idx] && !event_in[cur_idx] |-> !timer_run;
	endproperty
	a_event_gate: assert property (p_event_gate) else $error("timer ran without event"); // [RL6]

	property p_done_set;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && state_q == sds_pkg::SDS_RUN && !reset_in && start && !(event_variant && jog_rise)
		&& cur_event_ok && count_q == step_counts[cur_idx] && step_q >= last_step
		|=> done_q && state_q == sds_pkg::SDS_DONE;
	endproperty
	a_done_set: assert property (p_done_set) else $error("completion bit not set"); // [RL11]

	property p_done_clear;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && reset_in |=> !drum_done;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("completion bit not cleared"); // [RL11]

	property p_preset_write;
		@(posedge clk_sys) disable iff (sys_rst)
		preset_wr |=> status_preset == {11'h000, $past(preset_step_value)};
	endproperty
	a_preset_write: assert property (p_preset_write) else $error("preset word not written"); // [RL10]

	property p_outputs_off;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && !run_mode |=> drum_out == '0;
	endproperty
	a_outputs_off: assert property (p_outputs_off) else $error("outputs on outside run mode"); // [RL13]

	property p_count_up;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && state_q == sds_pkg::SDS_RUN && !reset_in && start && !(event_variant && jog_rise)
		&& cur_event_ok && count_q != step_counts[cur_idx] && tick_pend_q
		|=> count_q == $past(count_q) + 14'h0001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("timer count not taken"); // [RL2]

	property p_stand;
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(scan_tick) && !$past(sys_rst) |-> $stable(step_q) && $stable(drum_out) && $stable(done_q);
	endproperty
	a_stand: assert property (p_stand) else $error("state moved between scans"); // [RL22]

	property p_jog_done;
		@(posedge clk_sys) disable iff (sys_rst)
		scan_tick && run_mode && state_q == sds_pkg::SDS_RUN && !reset_in && event_variant && jog_rise
		&& step_q >= last_step |=> done_q && $stable(step_q);
	endproperty
	a_jog_done: assert property (p_jog_done) else $error("jog at last step did not complete"); // [RL8] [RL21]
endmodule : sds_sequencer

// [hdl/sds_pkg.sv]
// Shared constants and types of the step drum sequencer.
package sds_pkg;
	localparam int STEPS = 16;
	localparam int OUTS = 16;
	localparam int CNT_W = 14;
	localparam int STEP_W = 5;
	localparam int WORD_W = 16;
	localparam int IDX_W = 4;
	localparam int HUND_W = 14;

	// Step numbers as the program sees them run from 1 to 16.
	localparam logic [STEP_W-1:0] STEP_FIRST = 5'h01;
	localparam logic [STEP_W-1:0] STEP_LAST = 5'h10;
	localparam logic [STEP_W-1:0] PRESET_RESET = 5'h01;
	localparam logic [CNT_W-1:0] COUNT_BLANK = 14'h0000;

	// One timer count is the timebase value times one hundredth of a second.
	localparam int CLK_HZ = 10_000_000;
	localparam int HUNDREDTH_PER_S = 100;
	localparam int HUNDREDTH_CYCLES = CLK_HZ / HUNDREDTH_PER_S;

	typedef enum logic [1:0] {
		SDS_TIMED = 2'h0,
		SDS_EVENT = 2'h1,
		SDS_MASKED = 2'h2
	} sds_variant_t;

	typedef enum logic [1:0] {
		SDS_PROG = 2'h0,
		SDS_RUN = 2'h1,
		SDS_DONE = 2'h3
	} sds_state_t;
endpackage : sds_pkg

// [hdl/sds_timebase.sv]
// Hundredth-second divider that emits one pulse per drum timer count.
module sds_timebase #(
	parameter int HUNDREDTH_CYCLES = sds_pkg::HUNDREDTH_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Control
	input wire logic run,
	input wire logic clear,
	input wire logic [sds_pkg::HUND_W-1:0] timebase_value,
	// Result
	output logic count_pulse,
	output logic [sds_pkg::HUND_W-1:0] hundredths
);
	logic [31:0] div_q;
	logic [sds_pkg::HUND_W-1:0] hund_q;
	logic [sds_pkg::HUND_W-1:0] limit;
	logic hund_end;

	// A timebase of zero is taken as one hundredth so the timer never stalls.
	assign limit = (timebase_value == '0) ? 14'h0001 : timebase_value;
	assign hund_end = run && (div_q == 32'(HUNDREDTH_CYCLES - 1));

	always_ff @(posedge clk_sys) begin
		if (sys_rst || clear) begin
			div_q <= 32'h0;
		end else if (hund_end) begin
			div_q <= 32'h0;
		end else if (run) begin
			div_q <= div_q + 32'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst || clear) begin
			hund_q <= '0;
			count_pulse <= 1'b0;
		end else begin
			count_pulse <= 1'b0;
			if (hund_end) begin
				if (hund_q + 14'h0001 >= limit) begin
					hund_q <= '0;
					count_pulse <= 1'b1;
				end else begin
					hund_q <= hund_q + 14'h0001;
				end
			end
		end
	end

	assign hundredths = hund_q;
endmodule : sds_timebase

// [sim/sds_ladder.sv]
// Controlling program model: scan pulses and the per-step count table.
module sds_ladder #(
	parameter int SCAN = 20
) (
	// Clock
	input wire logic clk_sys,
	// Programme
	input wire logic [sds_pkg::STEP_W-1:0] last_step,
	input wire logic [sds_pkg::CNT_W-1:0] cnt_val,
	// Outputs to the drum
	output logic scan_tick,
	output logic [sds_pkg::STEPS*sds_pkg::CNT_W-1:0] counts_flat
);
	timeunit 1ns;
	timeprecision 1ns;
	int cyc = 0;
	initial scan_tick = 1'b0;
	// The scan pulse is launched on the falling edge so the drum samples it cleanly.
	always @(negedge clk_sys) begin
		cyc <= (cyc == SCAN - 1) ? 0 : cyc + 1;
		scan_tick <= (cyc == SCAN - 1);
	end
	// Steps past the last used one carry the blank count.
	always_comb begin
		for (int k = 0; k < sds_pkg::STEPS; k++) begin
			counts_flat[k*sds_pkg::CNT_W +: sds_pkg::CNT_W] = (k < int'(last_step)) ? cnt_val : sds_pkg::COUNT_BLANK;
		end
	end
endmodule : sds_ladder

// [sim/step_drum_sequencer_test.sv]
// Self-checking bench of the step drum sequencer against an integer model.
module step_drum_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, sys_rst = 1'b1, run_mode = 1'b0, start = 1'b0, jog = 1'b0, reset_in = 1'b0;
	logic preset_wr = 1'b0, scan_tick, drum_done;
	sds_pkg::sds_variant_t variant = sds_pkg::SDS_EVENT;
	logic [sds_pkg::STEP_W-1:0] last_step = sds_pkg::STEP_LAST, preset_step_value = 5'h01;
	logic [sds_pkg::HUND_W-1:0] timebase_value = 14'h0001;
	logic [sds_pkg::CNT_W-1:0] cnt_val = 14'h0000;
	logic [sds_pkg::STEPS*sds_pkg::OUTS-1:0] pattern_flat = '0;
	logic [sds_pkg::STEPS*sds_pkg::WORD_W-1:0] mask_flat = '0;
	logic [sds_pkg::STEPS-1:0] event_used = '0, event_in = '1;
	logic [sds_pkg::IDX_W-1:0] mask_base = 4'h0;
	logic [sds_pkg::STEPS*sds_pkg::CNT_W-1:0] counts_flat;
	logic [sds_pkg::OUTS-1:0] drum_out;
	logic [sds_pkg::WORD_W-1:0] status_count, status_timer, status_preset, status_step;
	int n_errors = 0, num_checks = 0, cycles = 0, seed = 32'h3a1f3c9b;
	int m_step = 1, m_preset = 1, m_done = 0, m_jog = 0, m_run = 0, ps, pc, n;

	initial forever #50 clk_sys = ~clk_sys;

	sds_ladder #(.SCAN(20)) sds_ladder_inst (.clk_sys(clk_sys), .last_step(last_step), .cnt_val(cnt_val),
		.scan_tick(scan_tick), .counts_flat(counts_flat));
	sds_sequencer #(.HUNDREDTH_CYCLES(10)) sds_sequencer_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.scan_tick(scan_tick), .run_mode(run_mode), .variant(variant), .start(start), .jog(jog),
		.reset_in(reset_in), .last_step(last_step), .timebase_value(timebase_value),
		.counts_flat(counts_flat), .pattern_flat(pattern_flat), .event_used(event_used),
		.event_in(event_in), .mask_flat(mask_flat), .mask_base(mask_base), .preset_wr(preset_wr),
		.preset_step_value(preset_step_value), .drum_out(drum_out), .drum_done(drum_done),
		.status_count(status_count), .status_timer(status_timer), .status_preset(status_preset),
		.status_step(status_step));

	task automatic end_of_test();
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// One controller scan: the model steps at the taking edge, results are read a half cycle later.
	task automatic scan(input bit cmp);
		logic [15:0] exp_out;
		@(posedge clk_sys iff scan_tick === 1'b1);
		if (run_mode && m_run == 0) begin
			m_step = m_preset;
		end else if (reset_in) begin
			m_step = m_preset;
			m_done = 0;
		end else if (m_done == 0 && ((jog && m_jog == 0 && variant != sds_pkg::SDS_TIMED) ||
			(start && (!event_used[m_step-1] || event_in[m_step-1]) && cnt_val == 14'h0000))) begin
			if (m_step == int'(last_step)) m_done = 1;
			else m_step++;
		end
		m_run = run_mode;
		m_jog = jog;
		@(negedge clk_sys);
		exp_out = pattern_flat[(m_step-1)*16 +: 16];
		if (variant == sds_pkg::SDS_MASKED) exp_out &= mask_flat[((int'(mask_base) + m_step - 1) % 16)*16 +: 16];
		if (!run_mode) exp_out = 16'h0000;
		if (cmp) begin
			check("status_step", m_step[15:0], status_step);
			check("drum_done", m_done[15:0], {15'h0000, drum_done});
			check("drum_out", exp_out, drum_out);
			check("status_count", 16'h0000, status_count);
		end
	endtask : scan

	task automatic set_preset(input logic [4:0] v);
		@(negedge clk_sys);
		preset_step_value = v;
		preset_wr = 1'b1;
		@(negedge clk_sys);
		preset_wr = 1'b0;
		m_preset = v;
		check("status_preset", {11'h000, v}, status_preset);
	endtask : set_preset

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end
	end

	initial begin
		for (int k = 0; k < 16; k++) begin
			pattern_flat[k*16 +: 16] = 16'($random(seed));
			mask_flat[k*16 +: 16] = 16'($random(seed));
		end
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		check("step after reset", 16'h0001, status_step);
		set_preset(5'h03);
		run_mode = 1'b1;
		scan(1);
		repeat (2) scan(1);
		for (int i = 0; i < 2; i++) begin
			jog = 1'b1;
			scan(1);
			jog = 1'b0;
			scan(1);
		end
		reset_in = 1'b1;
		jog = 1'b1;
		start = 1'b1;
		scan(1);
		jog = 1'b0;
		scan(1);
		reset_in = 1'b0;
		event_used = 16'h0004;
		event_in = 16'hfffb;
		repeat (3) scan(1);
		event_in = 16'hffff;
		scan(1);
		set_preset(5'h01);
		reset_in = 1'b1;
		scan(1);
		reset_in = 1'b0;
		repeat (16) scan(1);
		jog = 1'b1;
		scan(1);
		jog = 1'b0;
		variant = sds_pkg::SDS_MASKED;
		mask_base = 4'($random(seed));
		reset_in = 1'b1;
		scan(1);
		reset_in = 1'b0;
		repeat (5) scan(1);
		variant = sds_pkg::SDS_TIMED;
		event_used = '0;
		cnt_val = 14'h0002;
		last_step = 5'h02;
		reset_in = 1'b1;
		scan(1);
		reset_in = 1'b0;
		ps = 1;
		pc = 0;
		n = 0;
		for (int i = 0; i < 12 && drum_done !== 1'b1; i++) begin
			scan(0);
			check("status_timer", 16'h0000, status_timer);
			if (status_step !== ps[15:0]) begin
				check("count at advance", 16'h0002, pc[15:0]);
				if (ps == 1) check("timed scans in step", 16'h0001, {15'h0000, n >= 2});
				n = 0;
			end
			n++;
			ps = status_step;
			pc = status_count;
		end
		check("timed drum_done", 16'h0001, {15'h0000, drum_done});
		reset_in = 1'b1;
		scan(1);
		run_mode = 1'b0;
		scan(1);
		end_of_test();
	end
endmodule : step_drum_sequencer_test
